// ===== rtl/dcr_consts.svh
// Constants for the serial calibration register bank: frame layout, map, fields, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef DCR_CONSTS_SVH
`define DCR_CONSTS_SVH

`define DCR_NCHAN 8
`define DCR_FRAME_BITS 5'h18
`define DCR_CNT_MAX 5'h1F
`define DCR_CNT_ONE 5'h01
`define DCR_FRAME_MSB 23
`define DCR_OP_BIT 23
`define DCR_ADDR_MSB 20
`define DCR_ADDR_LSB 16
`define DCR_DATA_MSB 15

`define DCR_ADDR_CFG 5'h00
`define DCR_ADDR_SLEEP 5'h01
`define DCR_ADDR_BCAST 5'h07
`define DCR_BANK_DATA 2'h1
`define DCR_BANK_ZERO 2'h2
`define DCR_BANK_GAIN 2'h3

`define DCR_CFG_SCE_BIT 8
`define DCR_CFG_W2_BIT 4
`define DCR_SLEEP_BIT 15

`define DCR_RST_WORD 16'h0000
`define DCR_RST_DATA 16'h0000
`define DCR_RST_ZERO 16'h0000
`define DCR_RST_GAIN 16'h8000
`define DCR_RST_FRAME 24'h000000
`define DCR_GAIN_BIAS 17'h08000
`define DCR_CODE_MAX 16'hFFFF
`define DCR_SUM_MAX 19'h0FFFF

// Pin sampler order: SCLK, CS_B, SDI, RESUME_PIN_B, LATCH_LOAD_PIN_B
`define DCR_PIN_IDLE 5'h0B
`define DCR_PIN_SCLK 4
`define DCR_PIN_CS 3
`define DCR_PIN_SDI 2
`define DCR_PIN_RESUME 1
`define DCR_PIN_LOAD 0

`endif

// ===== rtl/dcr_pkg.sv
// Types shared by the calibration register bank and its trim engine.
// Assumes dcr_consts.svh is on the include path.
`default_nettype none
`include "dcr_consts.svh"

package dcr_pkg;
    typedef logic [15:0] dcr_word_t;
    typedef logic [4:0] dcr_addr_t;
    typedef logic [`DCR_NCHAN-1:0][15:0] dcr_bank_t;
    typedef enum logic {
        DCR_OP_WRITE = 1'b0,
        DCR_OP_READ = 1'b1
    } dcr_op_t;
endpackage

`default_nettype wire

// ===== rtl/dcr_trim_engine.sv
// Per-channel correction: code times gain coefficient plus signed offset, saturated.
// Assumes all inputs come from registers on the same clock; result is one cycle late.
`default_nettype none
`include "dcr_consts.svh"

module dcr_trim_engine (
    input wire logic clk,
    input wire logic rst_b,
    input wire dcr_pkg::dcr_word_t code,
    input wire dcr_pkg::dcr_word_t offset,
    input wire dcr_pkg::dcr_word_t gain,
    output var dcr_pkg::dcr_word_t corrected
);
    import dcr_pkg::*;

    logic [16:0] coeff;
    logic [32:0] product;
    logic [16:0] scaled;
    logic signed [18:0] sum;
    dcr_word_t corrected_next;

    // Coefficient is 0.5 + gain/65536, kept as a 17-bit fraction of 65536
    always_comb begin
        coeff = {1'b0, gain} + `DCR_GAIN_BIAS;
        product = {17'h00000, code} * {16'h0000, coeff};
        scaled = product[32:16];
        sum = $signed({2'b00, scaled}) + $signed({{3{offset[15]}}, offset});
        if (sum < 0) begin
            corrected_next = `DCR_RST_WORD;
        end else if (sum > $signed(`DCR_SUM_MAX)) begin
            corrected_next = `DCR_CODE_MAX;
        end else begin
            corrected_next = sum[15:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            corrected <= `DCR_RST_WORD;
        end else begin
            corrected <= corrected_next;
        end
    end
endmodule

`default_nettype wire

// ===== rtl/dcr_regs.sv
// Serial-reached register bank of an octal 16-bit converter: sleep control, broadcast,
// channel input data, zero and gain trims, correction path and output latches.
// Assumes the link pins are asynchronous to CLK and SCLK is well below CLK/4.
//
// Contract
// - Sleep bit set to one puts the serial port to sleep; zero means normal.
// - Reset pin and low resume pin force the sleep bit to zero.
// - In normal mode every input bit shifts into the shift register.
// - In sleep the input bits pass straight to the output, undecoded.
// - Broadcast writes load all eight channel data registers at once.
// - Broadcast writes are discarded while correction is enabled.
// - Reading the broadcast address returns zero.
// - With correction on, writes feed the correction engine before the converter.
// - With correction off, writes become converter data directly.
// - A latch load moves the converter data into the output latch.
// - Channel data registers reset to zero.
// - Zero trims are signed offsets, one code per count, reset zero.
// - Gain trims are 0.5 to 1.499985 coefficients, 8000h means unity.
// - Gain coefficient scales the code with one step per count.
// - With option set and resume high, chip-select rise ends sleep if few clocks.
// - With resume pin low the device stays in normal mode.
`default_nettype none
`include "dcr_consts.svh"

module dcr_regs (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic SCLK,
    input wire logic CS_B,
    input wire logic SDI,
    input wire logic RESUME_PIN_B,
    input wire logic LATCH_LOAD_PIN_B,
    output logic SDO,
    output logic SDO_OE,
    output dcr_pkg::dcr_bank_t CHANNEL_LATCH,
    output logic SLEEP_ACTIVE,
    output logic CORRECTION_ACTIVE
);
    import dcr_pkg::*;

    // Pin synchronisers: stage 1 feeds stage 2 only, stage 3 is kept for edge detection
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [4:0] pin_s3_reg;

    logic sclk_fall;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    logic in_frame;
    logic sdi_bit;
    logic resume_low;
    logic load_fall;

    logic [4:0] bit_cnt_reg;
    logic [4:0] bit_cnt_next;
    logic [`DCR_FRAME_MSB:0] shift_reg;
    logic [`DCR_FRAME_MSB:0] shift_next;
    logic sdo_next;
    logic sdo_oe_next;

    logic sleep_reg;
    logic sleep_next;
    logic sce_reg;
    logic w2_reg;

    dcr_op_t frame_op;
    dcr_addr_t frame_addr;
    dcr_word_t frame_data;
    logic frame_done;
    logic write_stb;
    logic read_stb;
    dcr_word_t read_word;
    dcr_word_t cfg_word;

    logic cfg_wr;
    logic sleep_wr;
    logic cs_wake;
    logic cnt_full;

    dcr_word_t chan_data_reg [`DCR_NCHAN];
    dcr_word_t zero_reg [`DCR_NCHAN];
    dcr_word_t gain_reg [`DCR_NCHAN];
    dcr_word_t dac_data_reg [`DCR_NCHAN];
    dcr_word_t corr_word [`DCR_NCHAN];
    dcr_word_t latch_reg [`DCR_NCHAN];

    // Reset to the idle pin levels so that no false edge follows reset
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pin_s1_reg <= `DCR_PIN_IDLE;
            pin_s2_reg <= `DCR_PIN_IDLE;
            pin_s3_reg <= `DCR_PIN_IDLE;
        end else begin
            pin_s1_reg <= {SCLK, CS_B, SDI, RESUME_PIN_B, LATCH_LOAD_PIN_B};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    assign sclk_fall = pin_s3_reg[`DCR_PIN_SCLK] & ~pin_s2_reg[`DCR_PIN_SCLK];
    assign sclk_rise = ~pin_s3_reg[`DCR_PIN_SCLK] & pin_s2_reg[`DCR_PIN_SCLK];
    assign cs_fall = pin_s3_reg[`DCR_PIN_CS] & ~pin_s2_reg[`DCR_PIN_CS];
    assign cs_rise = ~pin_s3_reg[`DCR_PIN_CS] & pin_s2_reg[`DCR_PIN_CS];
    assign in_frame = ~pin_s2_reg[`DCR_PIN_CS];
    assign sdi_bit = pin_s2_reg[`DCR_PIN_SDI];
    assign resume_low = ~pin_s2_reg[`DCR_PIN_RESUME];
    assign load_fall = pin_s3_reg[`DCR_PIN_LOAD] & ~pin_s2_reg[`DCR_PIN_LOAD];

    // Saturating, so a very long daisy-chain frame cannot wrap back to a wake count
    assign cnt_full = bit_cnt_reg == `DCR_CNT_MAX;

    // Falling SCLK edges in the current frame; counted in sleep too for the resume check
    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        if (cs_fall) begin
            bit_cnt_next = 5'h00;
        end else if (in_frame && sclk_fall && !cnt_full) begin
            bit_cnt_next = bit_cnt_reg + `DCR_CNT_ONE;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            bit_cnt_reg <= 5'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // Frame fields: the last 24 bits clocked in before chip select rises
    assign frame_op = dcr_op_t'(shift_reg[`DCR_OP_BIT]);
    assign frame_addr = shift_reg[`DCR_ADDR_MSB:`DCR_ADDR_LSB];
    assign frame_data = shift_reg[`DCR_DATA_MSB:0];
    // Short frames are dropped; long ones keep their last 24 bits, which suits daisy chains
    assign frame_done = cs_rise && !sleep_reg && bit_cnt_reg >= `DCR_FRAME_BITS;
    assign write_stb = frame_done && frame_op == DCR_OP_WRITE;
    assign read_stb = frame_done && frame_op == DCR_OP_READ;
    assign cfg_wr = write_stb && frame_addr == `DCR_ADDR_CFG;
    assign sleep_wr = write_stb && frame_addr == `DCR_ADDR_SLEEP;
    // At most one falling SCLK edge, so a real frame passing through never wakes the port
    assign cs_wake = sleep_reg && cs_rise && w2_reg && bit_cnt_reg <= `DCR_CNT_ONE;

    always_comb begin
        shift_next = shift_reg;
        if (read_stb) begin
            // Read answer goes out during the next frame
            shift_next = {shift_reg[`DCR_FRAME_MSB:`DCR_ADDR_LSB], read_word};
        end else if (in_frame && sclk_fall && !sleep_reg) begin
            shift_next = {shift_reg[`DCR_FRAME_MSB-1:0], sdi_bit};
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            shift_reg <= `DCR_RST_FRAME;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // Output pin: shift register MSB on rising SCLK, or the input itself while asleep
    always_comb begin
        sdo_next = SDO;
        sdo_oe_next = in_frame;
        if (sleep_reg) begin
            sdo_next = sdi_bit;
            sdo_oe_next = 1'b1;
        end else if (cs_fall || (in_frame && sclk_rise)) begin
            sdo_next = shift_reg[`DCR_FRAME_MSB];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            SDO <= 1'b0;
        end else begin
            SDO <= sdo_next;
        end
    end

    // Enable follows the synchronised chip select, so it lags the pin by three clocks
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            SDO_OE <= 1'b0;
        end else begin
            SDO_OE <= sdo_oe_next;
        end
    end

    // Sleep control; a low resume pin overrides everything else
    always_comb begin
        sleep_next = sleep_reg;
        if (resume_low) begin
            sleep_next = 1'b0;
        end else if (sleep_wr) begin
            sleep_next = frame_data[`DCR_SLEEP_BIT];
        end else if (cs_wake) begin
            sleep_next = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            sleep_reg <= 1'b0;
        end else begin
            sleep_reg <= sleep_next;
        end
    end

    // Only the two option bits of the configuration word are kept; the rest read zero
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            sce_reg <= 1'b0;
        end else if (cfg_wr) begin
            sce_reg <= frame_data[`DCR_CFG_SCE_BIT];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            w2_reg <= 1'b0;
        end else if (cfg_wr) begin
            w2_reg <= frame_data[`DCR_CFG_W2_BIT];
        end
    end

    // Status pins are flop copies, never decoded logic, so they cannot glitch
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            SLEEP_ACTIVE <= 1'b0;
        end else begin
            SLEEP_ACTIVE <= sleep_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            CORRECTION_ACTIVE <= 1'b0;
        end else begin
            CORRECTION_ACTIVE <= sce_reg;
        end
    end

    always_comb begin
        cfg_word = `DCR_RST_WORD;
        cfg_word[`DCR_CFG_SCE_BIT] = sce_reg;
        cfg_word[`DCR_CFG_W2_BIT] = w2_reg;
    end

    // Read decode; unmapped addresses read as zero
    always_comb begin
        if (frame_addr == `DCR_ADDR_CFG) begin
            read_word = cfg_word;
        end else if (frame_addr == `DCR_ADDR_SLEEP) begin
            read_word = {sleep_reg, 15'h0000};
        end else if (frame_addr == `DCR_ADDR_BCAST) begin
            read_word = `DCR_RST_WORD;
        end else if (frame_addr[4:3] == `DCR_BANK_DATA) begin
            read_word = chan_data_reg[frame_addr[2:0]];
        end else if (frame_addr[4:3] == `DCR_BANK_ZERO) begin
            read_word = zero_reg[frame_addr[2:0]];
        end else if (frame_addr[4:3] == `DCR_BANK_GAIN) begin
            read_word = gain_reg[frame_addr[2:0]];
        end else begin
            read_word = `DCR_RST_WORD;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < `DCR_NCHAN; ch++) begin : g_chan
            logic data_hit;
            logic bcast_hit;
            logic zero_hit;
            logic gain_hit;

            assign data_hit = frame_addr == {`DCR_BANK_DATA, 3'(ch)};
            assign zero_hit = frame_addr == {`DCR_BANK_ZERO, 3'(ch)};
            assign gain_hit = frame_addr == {`DCR_BANK_GAIN, 3'(ch)};
            assign bcast_hit = frame_addr == `DCR_ADDR_BCAST && !sce_reg;

            always_ff @(posedge CLK) begin
                if (!RST_B) begin
                    chan_data_reg[ch] <= `DCR_RST_DATA;
                end else if (write_stb && (data_hit || bcast_hit)) begin
                    chan_data_reg[ch] <= frame_data;
                end
            end

            always_ff @(posedge CLK) begin
                if (!RST_B) begin
                    zero_reg[ch] <= `DCR_RST_ZERO;
                end else if (write_stb && zero_hit) begin
                    zero_reg[ch] <= frame_data;
                end
            end

            always_ff @(posedge CLK) begin
                if (!RST_B) begin
                    gain_reg[ch] <= `DCR_RST_GAIN;
                end else if (write_stb && gain_hit) begin
                    gain_reg[ch] <= frame_data;
                end
            end

            // Engine runs all the time; its result is used only while correction is on
            dcr_trim_engine u_trim (
                .clk(CLK),
                .rst_b(RST_B),
                .code(chan_data_reg[ch]),
                .offset(zero_reg[ch]),
                .gain(gain_reg[ch]),
                .corrected(corr_word[ch])
            );

            // Converter data follows the trimmed code or the raw write
            always_ff @(posedge CLK) begin
                if (!RST_B) begin
                    dac_data_reg[ch] <= `DCR_RST_DATA;
                end else if (sce_reg) begin
                    dac_data_reg[ch] <= corr_word[ch];
                end else begin
                    dac_data_reg[ch] <= chan_data_reg[ch];
                end
            end

            // Load pin updates all latches together so channels change in step
            always_ff @(posedge CLK) begin
                if (!RST_B) begin
                    latch_reg[ch] <= `DCR_RST_DATA;
                end else if (load_fall) begin
                    latch_reg[ch] <= dac_data_reg[ch];
                end
            end

            assign CHANNEL_LATCH[ch] = latch_reg[ch];
        end
    endgenerate
endmodule

`default_nettype wire

// ===== tb/dcr_regs_checker.sv
// Port-level assertions for the calibration register bank.
// Assumes a bind onto dcr_regs with every port connected by name.
`default_nettype none

module dcr_regs_checker (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CS_B,
    input wire logic SDI,
    input wire logic RESUME_PIN_B,
    input wire logic LATCH_LOAD_PIN_B,
    input wire logic SDO,
    input wire logic SDO_OE,
    input wire dcr_pkg::dcr_bank_t CHANNEL_LATCH,
    input wire logic SLEEP_ACTIVE,
    input wire logic CORRECTION_ACTIVE
);
    timeunit 1ns;
    timeprecision 100ps;
    import dcr_pkg::*;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    sleep_echo_a: assert property (
        SLEEP_ACTIVE [*4] |-> SDO == $past(SDI, 3)) else $error("sleep echo wrong");
    sleep_drive_a: assert property (
        SLEEP_ACTIVE [*2] |-> SDO_OE) else $error("sleep output not driven");
    resume_clear_a: assert property (
        !RESUME_PIN_B [*5] |-> !SLEEP_ACTIVE) else $error("sleep kept with resume low");
    sleep_set_a: assert property (
        $rose(SLEEP_ACTIVE) |-> CS_B && $past(RESUME_PIN_B, 3)) else $error("sleep entered wrongly");
    reset_state_a: assert property (
        $rose(RST_B) |-> !SLEEP_ACTIVE && !CORRECTION_ACTIVE && CHANNEL_LATCH == '0) else $error("reset state");
    frame_drive_a: assert property (
        !CS_B [*5] |-> SDO_OE) else $error("output not driven in frame");
    idle_quiet_a: assert property (
        (CS_B && !SLEEP_ACTIVE) [*5] |-> !SDO_OE) else $error("output driven when idle");
    latch_hold_a: assert property (
        LATCH_LOAD_PIN_B [*6] |-> $stable(CHANNEL_LATCH)) else $error("latch moved without load");
    latch_cause_a: assert property (
        !$stable(CHANNEL_LATCH) |-> !$past(LATCH_LOAD_PIN_B, 2)) else $error("latch moved early");
    corr_quiet_a: assert property (
        !$stable(CORRECTION_ACTIVE) |-> CS_B) else $error("correction flag moved in frame");
endmodule

`default_nettype wire

// ===== tb/dcr_host_model.sv
// Host serial master: 24-bit frames MSB first, data set on clock rise for the device's fall.
// Assumes CLK is the bench clock; 4 CLK per phase gives the 200 ns link period.
`default_nettype none

module dcr_host_model (
    input wire logic CLK,
    input wire logic SDO,
    output logic SCLK,
    output logic CS_B,
    output logic SDI
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        SCLK = 1'b0;
        CS_B = 1'b1;
        SDI = 1'b0;
    end

    // Short counts exist only for the chip-select wake frame
    task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
        rx = 24'h000000;
        @(negedge CLK);
        CS_B = 1'b0;
        repeat (4) @(negedge CLK);
        for (int i = 0; i < n; i++) begin
            SDI = tx[23 - i];
            SCLK = 1'b1;
            repeat (4) @(negedge CLK);
            SCLK = 1'b0;
            repeat (4) @(negedge CLK);
            rx = {rx[22:0], SDO};
        end
        CS_B = 1'b1;
        // Stale data after release must not look driven
        SDI = ~SDI;
        repeat (12) @(negedge CLK);
    endtask
endmodule

`default_nettype wire

// ===== tb/tb_dac_data_calibration_regs.sv
// Self-checking bench for the calibration register bank through the serial host model.
// Assumes design, package, checker and host model are compiled first.
`default_nettype none

module tb_dac_data_calibration_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import dcr_pkg::*;
    logic CLK = 1'b0;
    logic RST_B, RESUME_PIN_B, LATCH_LOAD_PIN_B, SCLK, CS_B, SDI, SDO, SDO_OE, SLEEP_ACTIVE, CORRECTION_ACTIVE;
    dcr_bank_t CHANNEL_LATCH;
    logic [23:0] rx;
    dcr_word_t d;
    int miscompares = 0;
    int cmp_count = 0;
    dcr_word_t tc[4] = '{16'h8000, 16'hFFFF, 16'hFFFF, 16'h0001};
    dcr_word_t tg[4] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'h8000};
    dcr_word_t tz[4] = '{16'hFFFE, 16'h7FFF, 16'h7FFF, 16'h8000};

    dcr_regs dut (.CLK(CLK), .RST_B(RST_B), .SCLK(SCLK), .CS_B(CS_B), .SDI(SDI), .RESUME_PIN_B(RESUME_PIN_B),
        .LATCH_LOAD_PIN_B(LATCH_LOAD_PIN_B), .SDO(SDO), .SDO_OE(SDO_OE), .CHANNEL_LATCH(CHANNEL_LATCH),
        .SLEEP_ACTIVE(SLEEP_ACTIVE), .CORRECTION_ACTIVE(CORRECTION_ACTIVE));
    dcr_host_model host (.CLK(CLK), .SDO(SDO), .SCLK(SCLK), .CS_B(CS_B), .SDI(SDI));

    always #12.5 CLK = ~CLK;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input dcr_word_t v);
        host.xfer(24, {3'b000, a, v}, rx);
    endtask

    // Read answer only arrives in the following frame
    task automatic rd(input logic [4:0] a, output dcr_word_t v);
        host.xfer(24, {3'b100, a, 16'h0000}, rx);
        host.xfer(24, 24'h800000, rx);
        v = rx[15:0];
    endtask

    task automatic load();
        LATCH_LOAD_PIN_B = 1'b0;
        repeat (8) @(negedge CLK);
        LATCH_LOAD_PIN_B = 1'b1;
        repeat (4) @(negedge CLK);
    endtask

    function automatic dcr_word_t corr(input dcr_word_t c, input dcr_word_t g, input dcr_word_t z);
        longint s;
        s = ((longint'(c) * (longint'(g) + 64'h8000)) >>> 16) + longint'($signed(z));
        return s < 0 ? 16'h0000 : (s > 64'hFFFF ? 16'hFFFF : s[15:0]);
    endfunction

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        RST_B = 1'b0;
        RESUME_PIN_B = 1'b1;
        LATCH_LOAD_PIN_B = 1'b1;
        repeat (4) @(negedge CLK);
        RST_B = 1'b1;
        repeat (4) @(negedge CLK);
        check(16'({SLEEP_ACTIVE, CORRECTION_ACTIVE, SDO_OE}), 16'h0000);
        check(CHANNEL_LATCH[7], 16'h0000);
        rd(5'h18, d);
        check(d, 16'h8000);
        rd(5'h13, d);
        check(d, 16'h0000);
        rd(5'h0A, d);
        check(d, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr({2'b01, i[2:0]}, {i[7:0], 8'hA5});
        end
        load();
        for (int i = 0; i < 8; i++) begin
            check(CHANNEL_LATCH[i], {i[7:0], 8'hA5});
        end
        rd(5'h0B, d);
        check(d, 16'h03A5);
        wr(5'h07, 16'hA5C3);
        rd(5'h07, d);
        check(d, 16'h0000);
        load();
        for (int i = 0; i < 8; i++) begin
            check(CHANNEL_LATCH[i], 16'hA5C3);
        end
        wr(5'h00, 16'h0100);
        check(16'(CORRECTION_ACTIVE), 16'h0001);
        wr(5'h07, 16'h1111);
        for (int i = 0; i < 4; i++) begin
            wr({2'b11, i[2:0]}, tg[i]);
            wr({2'b10, i[2:0]}, tz[i]);
            wr({2'b01, i[2:0]}, tc[i]);
        end
        load();
        for (int i = 0; i < 8; i++) begin
            check(CHANNEL_LATCH[i], i < 4 ? corr(tc[i], tg[i], tz[i]) : 16'hA5C3);
        end
        wr(5'h00, 16'h0010);
        check(16'(CORRECTION_ACTIVE), 16'h0000);
        wr(5'h01, 16'h8000);
        check(16'(SLEEP_ACTIVE), 16'h0001);
        host.xfer(24, 24'h085A3C, rx);
        check(rx[15:0], 16'h5A3C);
        host.xfer(2, 24'h000000, rx);
        check(16'(SLEEP_ACTIVE), 16'h0001);
        host.xfer(1, 24'h000000, rx);
        check(16'(SLEEP_ACTIVE), 16'h0000);
        load();
        check(CHANNEL_LATCH[0], 16'h8000);
        wr(5'h01, 16'h8000);
        RESUME_PIN_B = 1'b0;
        repeat (8) @(negedge CLK);
        check(16'(SLEEP_ACTIVE), 16'h0000);
        wr(5'h01, 16'h8000);
        check(16'(SLEEP_ACTIVE), 16'h0000);
        RESUME_PIN_B = 1'b1;
        wr(5'h01, 16'h8000);
        check(16'(SLEEP_ACTIVE), 16'h0001);
        RST_B = 1'b0;
        repeat (4) @(negedge CLK);
        RST_B = 1'b1;
        repeat (4) @(negedge CLK);
        check(16'(SLEEP_ACTIVE), 16'h0000);
        check(CHANNEL_LATCH[0], 16'h0000);
        rd(5'h18, d);
        check(d, 16'h8000);
        rd(5'h08, d);
        check(d, 16'h0000);
        results();
    end

    initial begin
        repeat (40000) @(posedge CLK);
        miscompares++;
        results();
    end
endmodule

bind dcr_regs dcr_regs_checker chk (.CLK(CLK), .RST_B(RST_B), .CS_B(CS_B), .SDI(SDI), .RESUME_PIN_B(RESUME_PIN_B),
    .LATCH_LOAD_PIN_B(LATCH_LOAD_PIN_B), .SDO(SDO), .SDO_OE(SDO_OE), .CHANNEL_LATCH(CHANNEL_LATCH),
    .SLEEP_ACTIVE(SLEEP_ACTIVE), .CORRECTION_ACTIVE(CORRECTION_ACTIVE));

`default_nettype wire
